/* common/ioexp_defines.svh */
// Constants for the serial 24-bit I/O expander
`ifndef IOEXP_DEFINES_SVH
`define IOEXP_DEFINES_SVH

`define IOX_WIDTH        24
`define IOX_BITS_FULL    5'd24
`define IOX_DIR_RESET    24'h000000
`define IOX_LVL_RESET    24'hFFFFFF
`define IOX_FIFO_DEPTH   32
`define IOX_CLK_NS       10
`define IOX_SEL_LOW_NS   200
`define IOX_SEL_LOW_CYC  ((`IOX_SEL_LOW_NS + `IOX_CLK_NS - 1) / `IOX_CLK_NS)

`endif

/* common/ioexp_pkg.sv */
// Types shared by the serial 24-bit I/O expander
`include "ioexp_defines.svh"

package ioexp_pkg;

  typedef enum logic [1:0]
  {
    MODE_INIT = 2'b00,
    MODE_DATA = 2'b01
  } mode_e;

  typedef struct packed
  {
    logic                    to_dir;
    logic [`IOX_WIDTH-1:0]   data;
  } update_s;

  typedef struct packed
  {
    logic                    sck_s1;
    logic                    sck_s2;
    logic                    sck_d;
    logic                    cs_s1;
    logic                    cs_s2;
    logic                    cs_d;
    logic                    din_s1;
    logic                    din_s2;
    logic [`IOX_WIDTH-1:0]   pin_s1;
    logic [`IOX_WIDTH-1:0]   pin_s2;
    mode_e                   mode;
    logic [4:0]              bit_cnt;
    logic [4:0]              low_cnt;
    logic                    first;
    logic [`IOX_WIDTH-1:0]   shreg;
    logic [`IOX_WIDTH-1:0]   cap;
    logic [`IOX_WIDTH-1:0]   direction_type_reg;
    logic [`IOX_WIDTH-1:0]   output_level_reg;
    logic                    pend;
    update_s                 pend_word;
    logic                    dout;
    logic [`IOX_WIDTH-1:0]   pin_out;
    logic [`IOX_WIDTH-1:0]   pin_oe_n;
  } core_s;

endpackage

/* verilog/ioexp_fifo.sv */
// Parameterised valid/ready FIFO for register update words
`timescale 1ns/1ps
`default_nettype none

module ioexp_fifo
#(
  parameter int WIDTH = 25,
  parameter int DEPTH = 32
)
(
  input  wire logic             clk,        // System clock
  input  wire logic             resetn,     // Async reset, active low
  input  wire logic             in_valid,   // Write request
  output logic                  in_ready,   // Space available
  input  wire logic [WIDTH-1:0] in_data,    // Write word
  output logic                  out_valid,  // Word available
  input  wire logic             out_ready,  // Reader takes word
  output logic      [WIDTH-1:0] out_data    // Oldest word
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed
  {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr_ptr;
    logic [AW:0]                 rd_ptr;
  } fifo_s;

  fifo_s fifo_reg;
  fifo_s fifo_next;
  logic  full;
  logic  empty;

  // Extra pointer bit tells full from empty when the indices meet
  assign empty     = (fifo_reg.wr_ptr == fifo_reg.rd_ptr);
  assign full      = (fifo_reg.wr_ptr[AW] != fifo_reg.rd_ptr[AW]) &&
                     (fifo_reg.wr_ptr[AW-1:0] == fifo_reg.rd_ptr[AW-1:0]);
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = fifo_reg.mem[fifo_reg.rd_ptr[AW-1:0]];

  always_comb
  begin
    fifo_next = fifo_reg;
    if (in_valid && !full)
    begin
      fifo_next.mem[fifo_reg.wr_ptr[AW-1:0]] = in_data;
      fifo_next.wr_ptr = fifo_reg.wr_ptr + 1'b1;
    end
    if (out_ready && !empty)
    begin
      fifo_next.rd_ptr = fifo_reg.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fifo_reg <= '0;
    end
    else
    begin
      fifo_reg <= fifo_next;
    end
  end

endmodule

`default_nettype wire

/* verilog/serial_io_expander_24bit.sv */
// Serial-controlled 24-bit I/O expander core
//
// Notes on behaviour
// RULE1 - There are three 8-bit ports and each pin's direction is set alone.
// RULE2 - Each pin's driver is push-pull or open drain, chosen per bit.
// RULE3 - Each falling shift-clock edge puts the next bit on the output.
// RULE4 - The serial input is sampled on each rising shift-clock edge.
// RULE5 - Shifting happens only while the select input is held low.
// RULE6 - Reset returns sequencing and both configuration words to start.
// RULE7 - During reset the serial output is high and every pin floats.
// RULE8 - Type bit 0 is open drain, 1 is push-pull; level 0 drives low.
// RULE9 - A pin's level is captured only when it is open drain and high.
// RULE10 - Every other configuration reports that pin's input as high.
// RULE11 - Reset clears all type bits and sets all level bits.
// RULE12 - The first fall shows pin zero, the next rise loads the rest.
// RULE13 - The host sends pin zero first and the last pin of port two last.
// RULE14 - Select rising after 24 rises loads type first, later the levels.
// RULE15 - A short first frame keeps type bits zero and enters data mode.
// RULE16 - Received bits follow the captured ones out, for chaining.
`timescale 1ns/1ps
`default_nettype none
`include "ioexp_defines.svh"

module serial_io_expander_24bit
(
  input  wire logic                  CLK,       // System clock, 100 MHz
  input  wire logic                  RESETN,    // Async reset, active low
  input  wire logic                  SCK,       // Shift clock from host
  input  wire logic                  CS_N,      // Select, active low
  input  wire logic                  DIN,       // Serial data in
  output logic                       DOUT,      // Serial data out
  input  wire logic [`IOX_WIDTH-1:0] PIN_IN,    // Pin levels seen
  output logic      [`IOX_WIDTH-1:0] PIN_OUT,   // Pin drive level
  output logic      [`IOX_WIDTH-1:0] PIN_OE_N   // Pin drive enable, low
);

  import ioexp_pkg::*;

  localparam core_s RESET_STATE = '{
    sck_s1:             1'b1,
    sck_s2:             1'b1,
    sck_d:              1'b1,
    cs_s1:              1'b1,
    cs_s2:              1'b1,
    cs_d:               1'b1,
    mode:               MODE_INIT,
    direction_type_reg: `IOX_DIR_RESET,
    output_level_reg:   `IOX_LVL_RESET,
    dout:               1'b1,
    pin_oe_n:           24'hFFFFFF,
    default:            '0
  };

  core_s                   state_reg;
  core_s                   state_next;
  logic                    sel;
  logic                    cs_fall;
  logic                    cs_rise;
  logic                    sck_rise;
  logic                    sck_fall;
  logic [`IOX_WIDTH-1:0]   cap_val;
  logic [`IOX_WIDTH-1:0]   cap_en;
  logic [`IOX_WIDTH-1:0]   drv_out;
  logic [`IOX_WIDTH-1:0]   drv_oe_n;
  logic                    push_ready;
  logic                    pop_valid;
  logic                    pop_ready;
  update_s                 pop_word;
  logic                    cap0;
  logic                    sh0;
  logic                    shmsb;
  logic [`IOX_WIDTH-1:0]   pop_data;

  // Edges come from the synchronised copies only; the first stage is
  // never looked at, which costs two cycles of latency per edge.
  assign sel      = ~state_reg.cs_s2;
  assign cs_fall  = ~state_reg.cs_s2 &  state_reg.cs_d;
  assign cs_rise  =  state_reg.cs_s2 & ~state_reg.cs_d;
  assign sck_rise =  state_reg.sck_s2 & ~state_reg.sck_d;
  assign sck_fall = ~state_reg.sck_s2 &  state_reg.sck_d;

  genvar g;
  generate
    for (g = 0; g < `IOX_WIDTH; g = g + 1)
    begin : g_pin
      // Only an open-drain pin left floating is a real input
      assign cap_en[g]   = ~state_reg.direction_type_reg[g] &
                            state_reg.output_level_reg[g];  // RULE10
      assign cap_val[g]  = cap_en[g] ? state_reg.pin_s2[g] : 1'b1;  // RULE9
      // Floating only for open drain at level one
      assign drv_oe_n[g] = cap_en[g];                                 // RULE8
      assign drv_out[g]  = state_reg.direction_type_reg[g] &
                           state_reg.output_level_reg[g];             // RULE2
    end
  endgenerate

  // Update words are applied only between frames so that a frame in
  // progress never sees its configuration change under it.
  assign pop_ready = ~sel;
  assign pop_data  = pop_word.data;
  assign cap0      = cap_val[0];
  assign sh0       = state_reg.shreg[0];
  assign shmsb     = state_reg.shreg[`IOX_WIDTH-1];

  ioexp_fifo
  #(
    .WIDTH ($bits(update_s)),
    .DEPTH (`IOX_FIFO_DEPTH)
  )
  u_fifo
  (
    .clk       (CLK),
    .resetn    (RESETN),
    .in_valid  (state_reg.pend),
    .in_ready  (push_ready),
    .in_data   (state_reg.pend_word),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_word)
  );

  always_comb
  begin
    state_next = state_reg;

    state_next.sck_s1 = SCK;
    state_next.sck_s2 = state_reg.sck_s1;
    state_next.sck_d  = state_reg.sck_s2;
    state_next.cs_s1  = CS_N;
    state_next.cs_s2  = state_reg.cs_s1;
    state_next.cs_d   = state_reg.cs_s2;
    state_next.din_s1 = DIN;
    state_next.din_s2 = state_reg.din_s1;
    state_next.pin_s1 = PIN_IN;
    state_next.pin_s2 = state_reg.pin_s1;

    if (sel && state_reg.low_cnt != 5'h1F)
    begin
      state_next.low_cnt = state_reg.low_cnt + 5'h01;
    end

    if (cs_fall)
    begin
      state_next.bit_cnt = 5'h00;
      state_next.low_cnt = 5'h00;
      state_next.first   = 1'b1;
    end
    else if (sel)                                                     // RULE5
    begin
      if (sck_fall)
      begin
        if (state_reg.first)
        begin
          state_next.cap  = cap_val;                                  // RULE12
          state_next.dout = cap_val[0];                               // RULE12
        end
        else
        begin
          state_next.dout = state_reg.shreg[0];                       // RULE3
        end
      end
      if (sck_rise)
      begin
        if (state_reg.first)
        begin
          state_next.shreg = {state_reg.din_s2,
                              state_reg.cap[`IOX_WIDTH-1:1]};         // RULE12
          state_next.first = 1'b0;
        end
        else
        begin
          // Received bits march toward the output behind the port bits
          state_next.shreg = {state_reg.din_s2,
                              state_reg.shreg[`IOX_WIDTH-1:1]};       // RULE16
        end
        if (state_reg.bit_cnt != `IOX_BITS_FULL)
        begin
          state_next.bit_cnt = state_reg.bit_cnt + 5'h01;             // RULE4
        end
      end
    end

    // Acceptance clears first so a new frame end in the same cycle wins
    if (state_reg.pend && push_ready)
    begin
      state_next.pend = 1'b0;
    end

    if (cs_rise)
    begin
      case (state_reg.mode)
        MODE_INIT:
        begin
          if (state_reg.bit_cnt == `IOX_BITS_FULL)
          begin
            state_next.pend      = 1'b1;                              // RULE14
            state_next.pend_word = '{to_dir: 1'b1,
                                     data:   state_reg.shreg};
            state_next.mode      = MODE_DATA;
          end
          else if (state_reg.low_cnt >= `IOX_SEL_LOW_CYC)
          begin
            state_next.mode = MODE_DATA;                              // RULE15
          end
        end
        MODE_DATA:
        begin
          if (state_reg.bit_cnt == `IOX_BITS_FULL)
          begin
            state_next.pend      = 1'b1;                              // RULE14
            state_next.pend_word = '{to_dir: 1'b0,
                                     data:   state_reg.shreg};
          end
        end
        default:
        begin
          state_next.mode = MODE_INIT;
        end
      endcase
    end

    if (pop_valid && pop_ready)
    begin
      if (pop_word.to_dir)
      begin
        state_next.direction_type_reg = pop_word.data;                // RULE1
      end
      else
      begin
        state_next.output_level_reg = pop_word.data;                  // RULE14
      end
    end

    state_next.pin_out  = drv_out;
    state_next.pin_oe_n = drv_oe_n;                                   // RULE8
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_reg <= RESET_STATE;                                // RULE6 RULE11
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign DOUT     = state_reg.dout;                                   // RULE7
  assign PIN_OUT  = state_reg.pin_out;
  assign PIN_OE_N = state_reg.pin_oe_n;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  AST_RESET_OUT: // RULE7
  assert property ($rose(RESETN) |-> (DOUT && (&PIN_OE_N)))
  else $error("Outputs not idle after reset");

  AST_RESET_REGS: // RULE6 RULE11
  assert property ($rose(RESETN) |->
                   (state_reg.direction_type_reg == `IOX_DIR_RESET &&
                    state_reg.output_level_reg == `IOX_LVL_RESET &&
                    state_reg.mode == MODE_INIT))
  else $error("Configuration not at start values after reset");

  AST_FIRST_FALL: // RULE12
  assert property ((sel && sck_fall && state_reg.first) |=>
                   (DOUT == $past(cap0)))
  else $error("First falling edge did not show pin zero");

  AST_FALL_SHIFT: // RULE3
  assert property ((sel && sck_fall && !state_reg.first) |=>
                   (DOUT == $past(sh0)))
  else $error("Falling edge did not present next bit");

  AST_RISE_SAMPLE: // RULE4
  assert property ((sel && sck_rise) |=> (shmsb == $past(state_reg.din_s2)))
  else $error("Rising edge did not sample serial input");

  AST_IDLE_HOLD: // RULE5
  assert property (!sel |=> ($stable(state_reg.shreg) && $stable(DOUT)))
  else $error("Shifting while not selected");

  AST_DRIVE: // RULE8 RULE2
  assert property (##1 ((PIN_OE_N == $past(cap_en)) &&
                        (PIN_OUT == $past(drv_out))))
  else $error("Pin drive does not follow configuration");

  AST_CAPTURE: // RULE9 RULE10
  assert property (((cap_val & cap_en) == (state_reg.pin_s2 & cap_en)) &&
                   ((cap_val | cap_en) == 24'hFFFFFF))
  else $error("Captured input wrong for configuration");

  AST_FIRST_DIR: // RULE14
  assert property ((cs_rise && state_reg.mode == MODE_INIT &&
                    state_reg.bit_cnt == `IOX_BITS_FULL) |=>
                   (state_reg.pend && state_reg.pend_word.to_dir &&
                    state_reg.mode == MODE_DATA))
  else $error("First full frame not aimed at type word");

  AST_APPLY_LEVEL: // RULE14
  assert property ((pop_valid && pop_ready && !pop_word.to_dir) |=>
                   (state_reg.output_level_reg == $past(pop_data)))
  else $error("Level word not applied");

  AST_SHORT_INIT: // RULE15
  assert property ((cs_rise && state_reg.mode == MODE_INIT &&
                    state_reg.bit_cnt != `IOX_BITS_FULL &&
                    state_reg.low_cnt >= `IOX_SEL_LOW_CYC) |=>
                   (state_reg.mode == MODE_DATA &&
                    state_reg.direction_type_reg == `IOX_DIR_RESET))
  else $error("Short first frame did not enter data mode");

endmodule

`default_nettype wire

/* verif/ioexp_host_model.sv */
// Host model: synchronous serial master driving the expander link
`timescale 1ns/1ps
`default_nettype none

module ioexp_host_model
(
  output var  logic SCK,  // Shift clock, idles high
  output var  logic CS_N, // Select, active low
  output var  logic DIN,  // Serial data to expander
  input  wire logic DOUT  // Serial data from expander
);
  initial
  begin
    SCK  = 1'b1;
    CS_N = 1'b1;
    DIN  = 1'b0;
  end

  // Shifts n bits, tx bit 0 first; rx bit k is DOUT seen before rise k
  task automatic xfer(input int n, input logic [47:0] tx,
                      output logic [47:0] rx);
    rx   = '0;
    CS_N = 1'b0;
    #200;
    for (int i = 0; i < n; i++)
    begin
      SCK = 1'b0;
      DIN = tx[i];
      #80;
      rx[i] = DOUT;
      // Data changes only on the fall, so it is stable across the rise
      SCK = 1'b1;
      #80;
    end
    #100;
    CS_N = 1'b1;
    // Released line shows no stale value
    DIN = ~DIN;
    #400;
  endtask

  // Clocks with select high; the expander must ignore them
  task automatic idle(input int n);
    for (int i = 0; i < n; i++)
    begin
      SCK = 1'b0;
      DIN = ~DIN;
      #80;
      SCK = 1'b1;
      #80;
    end
    #400;
  endtask
endmodule

`default_nettype wire

/* verif/serial_io_expander_24bit_tb_top.sv */
// Testbench for the serial 24-bit I/O expander
`timescale 1ns/1ps
`default_nettype none

module serial_io_expander_24bit_tb_top;
  logic        clk;
  logic        resetn;
  logic        sck;
  logic        cs_n;
  logic        din;
  logic        dout;
  logic [23:0] pin_out;
  logic [23:0] pin_oe_n;
  logic [23:0] pin_in;
  logic [23:0] ext;
  logic [23:0] typ;
  logic [23:0] lvl;
  logic [47:0] rx;
  logic        dout_held;
  int          num_errors;
  int          total_checks;

  serial_io_expander_24bit u_dut
  (
    .CLK      (clk),
    .RESETN   (resetn),
    .SCK      (sck),
    .CS_N     (cs_n),
    .DIN      (din),
    .DOUT     (dout),
    .PIN_IN   (pin_in),
    .PIN_OUT  (pin_out),
    .PIN_OE_N (pin_oe_n)
  );

  ioexp_host_model u_host
  (
    .SCK  (sck),
    .CS_N (cs_n),
    .DIN  (din),
    .DOUT (dout)
  );

  // Released pins take the external level ext, which stands in for outside drivers
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext);

  initial
  begin
    clk = 1'b0;
  end

  always #5 clk = ~clk;

  function automatic logic [23:0] cap_exp(input logic [23:0] t,
                                          input logic [23:0] l);
    logic [23:0] en;
    en = ~t & l;
    return (en & ext) | ~en;
  endfunction

  task automatic chk(input logic [23:0] got, input logic [23:0] exp,
                     input string msg);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Only driven pins carry a meaningful output level
  task automatic pins(input logic [23:0] t, input logic [23:0] l);
    chk(pin_oe_n, ~t & l, "pin enable");
    chk(pin_out & ~pin_oe_n, t & l, "pin level");
  endtask

  task automatic results;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial
  begin
    #100000;
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    results;
  end

  initial
  begin
    resetn       = 1'b0;
    ext          = 24'h5AC396;
    num_errors   = 0;
    total_checks = 0;
    repeat (12) @(posedge clk);
    chk(24'(dout), 24'h000001, "dout in reset");
    pins(24'h000000, 24'hFFFFFF);
    #1 resetn = 1'b1;
    repeat (10) @(posedge clk);
    // Link changes then stay 1 ns off the sampling edge
    #1;
    $display("test reset done");

    typ = 24'h0F0F33;
    u_host.xfer(24, {24'h000000, typ}, rx);
    chk(rx[23:0], ext, "first capture");
    pins(typ, 24'hFFFFFF);
    $display("test type load done");

    lvl = 24'hA53CC3;
    u_host.xfer(24, {24'h000000, lvl}, rx);
    chk(rx[23:0], cap_exp(typ, 24'hFFFFFF), "masked capture");
    pins(typ, lvl);
    $display("test level load done");

    u_host.xfer(48, {24'h3C5A0F, 24'hC31E77}, rx);
    chk(rx[23:0], cap_exp(typ, lvl), "chain capture");
    chk(rx[47:24], 24'hC31E77, "chain passthrough");
    lvl = 24'h3C5A0F;
    pins(typ, lvl);
    $display("test chain done");

    u_host.xfer(12, 48'h000000000000, rx);
    pins(typ, lvl);
    dout_held = dout;
    u_host.idle(5);
    chk(24'(dout), 24'(dout_held), "dout with select high");
    pins(typ, lvl);
    $display("test short frame done");

    @(posedge clk);
    #1 resetn = 1'b0;
    repeat (3) @(posedge clk);
    chk(24'(dout), 24'h000001, "dout in second reset");
    pins(24'h000000, 24'hFFFFFF);
    #1 resetn = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    u_host.xfer(0, 48'h000000000000, rx);
    lvl = 24'h96F00F;
    u_host.xfer(24, {24'h000000, lvl}, rx);
    chk(rx[23:0], ext, "capture after select-only");
    pins(24'h000000, lvl);
    $display("test select-only start done");

    results;
  end
endmodule

`default_nettype wire
